// ### inc/tlic_defines.svh
// Constants for the two-level interrupt controller: addresses, fields, resets, timing
`ifndef TLIC_DEFINES_SVH
`define TLIC_DEFINES_SVH

// Special-function addresses, seen on every register page
`define TLIC_ADDR_ENABLE_PRI 8'hA8
`define TLIC_ADDR_PRIO_PRI 8'hB8
`define TLIC_ADDR_ENABLE_EXT1 8'hE6
`define TLIC_ADDR_ENABLE_EXT2 8'hE7

// Reset values
`define TLIC_RST_ENABLE_PRI 8'h00
`define TLIC_RST_PRIO_PRI 8'hC0
`define TLIC_RST_ENABLE_EXT1 8'h00
`define TLIC_RST_ENABLE_EXT2 8'h00

// Field positions and masks
`define TLIC_BIT_GLOBAL_EN 7
`define TLIC_BIT_SCRATCH 6
`define TLIC_PRIO_PRI_FIXED 8'hC0
`define TLIC_PRIO_PRI_WMASK 8'h3F
`define TLIC_ENABLE_EXT2_WMASK 8'h5F
`define TLIC_PRI_SRC_COUNT 6
`define TLIC_EXT2_SERIAL1_BIT 6

// Source numbering and vector layout
`define TLIC_NUM_SRC 20
`define TLIC_SERIAL1_IDX 5'h13
`define TLIC_SERIAL1_RANK 5'h14
`define TLIC_VEC_BASE 16'h0003
`define TLIC_VEC_SHIFT 3

// Timing in system clock cycles
`define TLIC_DETECT_CYC 1
`define TLIC_CALL_CYC 4
`define TLIC_RETURN_FROM_INTERRUPT_CYC 5
`define TLIC_DIV_CYC 8
`define TLIC_BEST_CYC (`TLIC_DETECT_CYC + `TLIC_CALL_CYC)
`define TLIC_WORST_CYC (`TLIC_DETECT_CYC + `TLIC_RETURN_FROM_INTERRUPT_CYC + `TLIC_DIV_CYC + `TLIC_CALL_CYC)

`endif

// ### inc/tlic_pkg.sv
// Types shared by the two-level interrupt controller
package tlic_pkg;
    typedef logic [4:0] tlic_src_t;
    typedef logic [19:0] tlic_vec_t;
    typedef enum logic [0:0] {st_idle, st_call} tlic_call_state_t;
endpackage

// ### design/tlic_arbiter.sv
// Two-level fixed-order arbiter over all interrupt sources
`timescale 1ns/10ps
module tlic_arbiter #(
    parameter int NUM_SRC = 20
) (
    input wire logic clk, // system clock, used by checks only
    input wire logic rst_n, // synchronised reset, used by checks only
    input wire logic [NUM_SRC-1:0] req, // enabled pending requests
    input wire logic [NUM_SRC-1:0] prio_hi, // per-source high level select
    output logic win_valid, // some request present
    output logic win_hi, // winner is at high level
    output tlic_pkg::tlic_src_t win_idx // winning source index
);
    logic [NUM_SRC-1:0] req_hi;
    logic [NUM_SRC-1:0] req_lo;

    // Lowest index wins within one level
    function automatic tlic_pkg::tlic_src_t first_set(input logic [NUM_SRC-1:0] v);
        tlic_pkg::tlic_src_t r;
        r = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (v[i])
                r = tlic_pkg::tlic_src_t'(i);
        end
        return r;
    endfunction

    function automatic logic [NUM_SRC-1:0] below(input tlic_pkg::tlic_src_t idx);
        logic [NUM_SRC-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            m[i] = (tlic_pkg::tlic_src_t'(i) < idx);
        end
        return m;
    endfunction

    assign req_hi = req & prio_hi;
    assign req_lo = req & ~prio_hi;
    assign win_valid = |req;
    assign win_hi = |req_hi;
    assign win_idx = win_hi ? first_set(req_hi) : first_set(req_lo);

    hi_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        (|req_hi) |-> (win_hi && prio_hi[win_idx] && req[win_idx]))
        else $error("high level request not chosen first");

    rank_order_a: assert property (@(posedge clk) disable iff (!rst_n)
        win_valid |-> (((win_hi ? req_hi : req_lo) & below(win_idx)) == '0))
        else $error("lower ranked source skipped at same level");
endmodule // tlic_arbiter

// ### design/tlic_top.sv
// Two-level interrupt controller: enable/priority registers, arbitration, vector calls
//
// Summary of operation
// - Each source picks low or high level through its own priority bit.
// - An enabled high request may preempt a running low-level routine.
// - While a high routine runs, nothing vectors until it returns.
// - Primary priority bits 0 to 5 are low after reset.
// - Simultaneous requests at both levels: the high one is served first.
// - Same-level ties go to the lower source rank.
// - Pending requests are sampled and decoded every clock.
// - Best response is 5 clocks: 1 detect plus 4 for the vector call.
// - After a return with a request pending, one more instruction runs first.
// - Worst response is 18 clocks: detect, return, divide, vector call.
// - Equal or lower requests wait for the return and the next instruction.
// - Global enable bit 7 off blocks all; on, each source follows its enable.
// - Enable register bit 6 is a software-only scratch flag.
// - Primary enable bits 0 to 5 enable the six legacy sources in order.
// - Primary priority bits 0 to 5 raise the six legacy sources.
// - Primary priority bits 7 and 6 read one, ignore writes.
// - First extended enable bits 0 to 7 enable the eight next sources.
// - Second extended enable bits 0 to 4 and 6 enable the last six sources.
// - Second extended enable bits 7 and 5 read zero, ignore writes.
// - The registers answer at fixed addresses on every register page.
// - Pending flags exist regardless; only enabled ones make a request.
// - Each source has a fixed vector, eight bytes apart by rank, and rank.
`timescale 1ns/10ps
`include "tlic_defines.svh"
module tlic_top #(
    parameter int NUM_SRC = `TLIC_NUM_SRC,
    parameter int CALL_CYC = `TLIC_CALL_CYC
) (
    input wire logic clk, // system clock, 10 MHz
    input wire logic nrst, // asynchronous reset, active low
    input wire logic [7:0] sfr_addr, // special-function address
    input wire logic sfr_wr, // write strobe, one cycle
    input wire logic [7:0] sfr_wdata, // write data
    input wire logic sfr_rd, // read strobe, one cycle
    output logic [7:0] sfr_rdata, // read data, valid the cycle after sfr_rd
    input wire logic [NUM_SRC-1:0] pend_flag, // peripheral pending flags
    input wire logic [NUM_SRC-7:0] ext_high_prio, // high level select, sources 6 up
    input wire logic cpu_instr_done, // an instruction completes this cycle
    input wire logic cpu_return_from_interrupt, // the completing instruction is a return
    output logic vec_call, // start the vector call, one cycle
    output logic [15:0] vec_addr, // vector address of the call
    output tlic_pkg::tlic_src_t vec_src, // source index of the call
    output logic call_active, // vector call in progress
    output logic in_service_hi, // a high-level routine is running
    output logic in_service_lo // a low-level routine is running
);
    logic rst_meta;
    logic rst_n;
    logic [7:0] enable_pri;
    logic [5:0] prio_pri;
    logic [7:0] enable_ext1;
    logic [7:0] enable_ext2;
    logic [NUM_SRC-1:0] enable_vec;
    logic [NUM_SRC-1:0] prio_vec;
    logic [NUM_SRC-1:0] req;
    logic arb_valid;
    logic arb_hi;
    tlic_pkg::tlic_src_t arb_idx;
    logic win_valid;
    logic win_hi;
    tlic_pkg::tlic_src_t win_idx;
    logic level_ok;
    logic take;
    tlic_pkg::tlic_call_state_t call_state;
    tlic_pkg::tlic_call_state_t next_call_state;
    logic [2:0] call_cnt;
    logic [7:0] next_rdata;

    // Release of reset goes through two flops so every flop leaves reset together
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Vector address from the source index; the last source skips one rank
    function automatic logic [15:0] vector_of(input tlic_pkg::tlic_src_t idx);
        tlic_pkg::tlic_src_t rank;
        rank = (idx == `TLIC_SERIAL1_IDX) ? `TLIC_SERIAL1_RANK : idx;
        return `TLIC_VEC_BASE + (16'(rank) << `TLIC_VEC_SHIFT);
    endfunction

    // Registers decode the same on every page, so no page input is taken
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_pri <= `TLIC_RST_ENABLE_PRI;
            enable_ext1 <= `TLIC_RST_ENABLE_EXT1;
            enable_ext2 <= `TLIC_RST_ENABLE_EXT2;
        end
        else if (sfr_wr)
        begin
            case (sfr_addr)
                `TLIC_ADDR_ENABLE_PRI: enable_pri <= sfr_wdata;
                `TLIC_ADDR_ENABLE_EXT1: enable_ext1 <= sfr_wdata;
                `TLIC_ADDR_ENABLE_EXT2: enable_ext2 <= sfr_wdata & `TLIC_ENABLE_EXT2_WMASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prio_pri <= 6'(`TLIC_RST_PRIO_PRI);
        else if (sfr_wr && sfr_addr == `TLIC_ADDR_PRIO_PRI)
            prio_pri <= 6'(sfr_wdata & `TLIC_PRIO_PRI_WMASK);
    end

    always_comb
    begin
        case (sfr_addr)
            `TLIC_ADDR_ENABLE_PRI: next_rdata = enable_pri;
            `TLIC_ADDR_PRIO_PRI: next_rdata = `TLIC_PRIO_PRI_FIXED | {2'h0, prio_pri};
            `TLIC_ADDR_ENABLE_EXT1: next_rdata = enable_ext1;
            `TLIC_ADDR_ENABLE_EXT2: next_rdata = enable_ext2 & `TLIC_ENABLE_EXT2_WMASK;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sfr_rdata <= 8'h00;
        else if (sfr_rd)
            sfr_rdata <= next_rdata;
    end

    // Source order follows the fixed ranking; scratch bit 6 stays out of it
    assign enable_vec = {enable_ext2[`TLIC_EXT2_SERIAL1_BIT], enable_ext2[4:0],
        enable_ext1, enable_pri[`TLIC_PRI_SRC_COUNT-1:0]};
    assign prio_vec = {ext_high_prio, prio_pri};
    // Disabled flags may stand set; they simply never request
    assign req = pend_flag & enable_vec & {NUM_SRC{enable_pri[`TLIC_BIT_GLOBAL_EN]}};

    tlic_arbiter #(
        .NUM_SRC(NUM_SRC)
    ) u_arbiter (
        .clk(clk),
        .rst_n(rst_n),
        .req(req),
        .prio_hi(prio_vec),
        .win_valid(arb_valid),
        .win_hi(arb_hi),
        .win_idx(arb_idx)
    );

    // One detection clock: the decoded winner is taken every cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            win_valid <= 1'b0;
            win_hi <= 1'b0;
            win_idx <= '0;
        end
        else
        begin
            win_valid <= arb_valid;
            win_hi <= arb_hi;
            win_idx <= arb_idx;
        end
    end

    // High may enter over low; nothing enters over high
    assign level_ok = !in_service_hi && (win_hi || !in_service_lo);
    // Never at the boundary of a return, so one more instruction always runs
    assign take = win_valid && level_ok && cpu_instr_done && !cpu_return_from_interrupt
        && call_state == tlic_pkg::st_idle;

    always_comb
    begin
        case (call_state)
            tlic_pkg::st_idle: next_call_state = take ? tlic_pkg::st_call : tlic_pkg::st_idle;
            tlic_pkg::st_call: next_call_state = (call_cnt == 3'(CALL_CYC - 1)) ?
                tlic_pkg::st_idle : tlic_pkg::st_call;
            default: next_call_state = tlic_pkg::st_idle;
        endcase
    end

    // The call occupies the sequencer for its full length before the next decision
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            call_state <= tlic_pkg::st_idle;
            call_cnt <= 3'h0;
        end
        else
        begin
            call_state <= next_call_state;
            if (call_state == tlic_pkg::st_call)
                call_cnt <= call_cnt + 3'h1;
            else
                call_cnt <= 3'h0;
        end
    end

    assign call_active = (call_state == tlic_pkg::st_call);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vec_call <= 1'b0;
            vec_addr <= 16'h0000;
            vec_src <= '0;
        end
        else
        begin
            vec_call <= take;
            if (take)
            begin
                vec_addr <= vector_of(win_idx);
                vec_src <= win_idx;
            end
        end
    end

    // A return closes the innermost routine, which is high if one is open
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_service_hi <= 1'b0;
            in_service_lo <= 1'b0;
        end
        else
        begin
            if (take && win_hi)
                in_service_hi <= 1'b1;
            else if (cpu_return_from_interrupt && cpu_instr_done && in_service_hi)
                in_service_hi <= 1'b0;
            if (take && !win_hi)
                in_service_lo <= 1'b1;
            else if (cpu_return_from_interrupt && cpu_instr_done && !in_service_hi)
                in_service_lo <= 1'b0;
        end
    end

    global_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !enable_pri[`TLIC_BIT_GLOBAL_EN] |=> !take)
        else $error("vector taken while global enable off");

    hi_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        in_service_hi |=> !vec_call)
        else $error("vector taken inside a high routine");

    lo_preempt_a: assert property (@(posedge clk) disable iff (!rst_n)
        (take && in_service_lo) |-> (win_hi && !in_service_hi) ##1 in_service_hi)
        else $error("low routine entered by a non-high request");

    return_from_interrupt_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cpu_return_from_interrupt && cpu_instr_done) |=> !vec_call)
        else $error("vector taken at the return boundary");

    call_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        take |=> (vec_call && call_active) ##1 (!vec_call && call_active) [*3] ##1 !call_active)
        else $error("vector call length wrong");

    detect_a: assert property (@(posedge clk) disable iff (!rst_n)
        win_valid == $past(arb_valid) && win_idx == $past(arb_idx))
        else $error("request not sampled every clock");

    vector_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        (take && win_idx == 5'h00) |=> vec_addr == 16'h0003)
        else $error("first source vector wrong");

    prio_top_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sfr_rd && sfr_addr == `TLIC_ADDR_PRIO_PRI) |=> sfr_rdata[7:6] == 2'b11)
        else $error("priority top bits not read as ones");

    ext2_unused_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sfr_rd && sfr_addr == `TLIC_ADDR_ENABLE_EXT2) |=> !sfr_rdata[7] && !sfr_rdata[5])
        else $error("unused enable bits not read as zero");

    prio_reset_a: assert property (@(posedge clk)
        !rst_n |-> prio_pri == 6'h00)
        else $error("priority bits not low in reset");
endmodule // tlic_top

// ### verification/tlic_cpu_model.sv
// CPU sequencer stand-in: runs one instruction of a chosen length on request
`timescale 1ns/10ps
module tlic_cpu_model (
    input wire logic clk, // system clock
    input wire logic nrst, // reset, active low
    input wire logic start, // begin one instruction
    input wire logic is_ret, // that instruction is a return
    input wire logic [3:0] len, // its length in clocks
    input wire logic call_active, // vector call running
    output logic instr_done, // instruction completes, one cycle
    output logic return_from_interrupt // completing instruction is a return
);
    logic [3:0] cnt;
    logic ret_q;
    // Starts during a vector call are dropped, as the core is busy then
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt <= 4'h0;
            ret_q <= 1'b0;
        end
        else if (start && !call_active)
        begin
            cnt <= len;
            ret_q <= is_ret;
        end
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
    end
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            instr_done <= 1'b0;
            return_from_interrupt <= 1'b0;
        end
        else
        begin
            instr_done <= (cnt == 4'h1);
            return_from_interrupt <= (cnt == 4'h1) && ret_q;
        end
    end
endmodule // tlic_cpu_model

// ### verification/tlic_bench.sv
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/10ps
module tlic_bench;
    logic clk = 1'b0;
    logic nrst;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_rd = 1'b0;
    logic [19:0] pend_flag = 20'h00000;
    logic [13:0] ext_high_prio = 14'h0000;
    logic start = 1'b0;
    logic is_ret = 1'b0;
    logic [3:0] len = 4'h1;
    logic [7:0] sfr_rdata;
    logic [15:0] vec_addr;
    tlic_pkg::tlic_src_t vec_src;
    logic cpu_instr_done, cpu_return_from_interrupt, vec_call, call_active, in_service_hi, in_service_lo;
    logic [7:0] r_en, r_pri, r_e1, r_e2;
    logic [19:0] en, hi;
    logic got;
    integer seed = 73;
    integer n_fail = 0;
    integer checked = 0;
    integer cyc = 0;
    integer i, t;

    tlic_top u_dut (
        .clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .pend_flag(pend_flag), .ext_high_prio(ext_high_prio),
        .cpu_instr_done(cpu_instr_done), .cpu_return_from_interrupt(cpu_return_from_interrupt), .vec_call(vec_call),
        .vec_addr(vec_addr), .vec_src(vec_src), .call_active(call_active),
        .in_service_hi(in_service_hi), .in_service_lo(in_service_lo)
    );
    tlic_cpu_model u_cpu (
        .clk(clk), .nrst(nrst), .start(start), .is_ret(is_ret), .len(len),
        .call_active(call_active), .instr_done(cpu_instr_done), .return_from_interrupt(cpu_return_from_interrupt)
    );

    always #50 clk = ~clk;

    task automatic tally_and_finish;
        if (n_fail == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            n_fail = n_fail + 1;
            tally_and_finish;
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask

    // Read compare lives here so every register read is checked the same way
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1;
        chk({8'h00, sfr_rdata}, {8'h00, e});
    endtask

    task automatic cfg;
        wr(8'hA8, r_en);
        wr(8'hB8, r_pri);
        wr(8'hE6, r_e1);
        wr(8'hE7, r_e2);
    endtask

    // One instruction with new pending flags; got tells whether a call followed
    task automatic instr(input logic ret, input logic [3:0] l, input logic [19:0] p);
        integer w;
        w = 0;
        @(posedge clk);
        start <= 1'b1;
        is_ret <= ret;
        len <= l;
        pend_flag <= p;
        @(posedge clk);
        start <= 1'b0;
        while (cpu_instr_done !== 1'b1 && w < 40)
        begin
            @(posedge clk);
            w = w + 1;
        end
        #1;
        got = vec_call;
        w = 0;
        while (call_active === 1'b1 && w < 20)
        begin
            @(posedge clk);
            #1;
            w = w + 1;
        end
        if (got === 1'b1)
            chk(16'(w), 16'h0004);
    endtask

    // Reference arbiter: high level first, then lowest index
    function automatic integer pick(input logic [19:0] r, input logic [19:0] h);
        integer j;
        pick = -1;
        for (j = 19; j >= 0; j--)
            if (r[j] && (h[j] || !(|(r & h))))
                pick = j;
    endfunction

    task automatic trial(input logic [19:0] p);
        integer w;
        en = {r_e2[6], r_e2[4:0], r_e1, r_en[5:0]} & {20{r_en[7]}};
        hi = {ext_high_prio, r_pri[5:0]};
        w = pick(p & en, hi);
        instr(1'b0, 4'h1, p);
        chk(got, w >= 0);
        if (w >= 0)
        begin
            chk(vec_src, w[4:0]);
            chk(vec_addr, 16'(16'h0003 + 16'h0008 * (w == 19 ? 20 : w)));
            chk({in_service_hi, in_service_lo}, hi[w] ? 2'b10 : 2'b01);
            instr(1'b1, 4'h1, 20'h00000);
        end
    endtask

    initial
    begin
        // Scheduled so the falling edge reaches every reset flop at time zero
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'hA8, 8'h00);
        rd(8'hB8, 8'hC0);
        rd(8'hE6, 8'h00);
        rd(8'hE7, 8'h00);
        chk({in_service_hi, in_service_lo}, 2'b00);
        r_en = 8'hBF;
        r_pri = 8'h00;
        r_e1 = 8'hFF;
        r_e2 = 8'h5F;
        cfg;
        wr(8'h87, 8'hFF);
        rd(8'h87, 8'h00);
        rd(8'hA8, 8'hBF);
        for (i = 0; i < 20; i++)
            trial(20'h1 << i);
        r_pri = 8'h02;
        cfg;
        instr(1'b0, 4'h1, 20'h00001);
        chk(vec_src, 5'h00);
        instr(1'b0, 4'h1, 20'h00002);
        chk(vec_src, 5'h01);
        chk({in_service_hi, in_service_lo}, 2'b11);
        instr(1'b0, 4'h3, 20'h00004);
        chk(got, 1'b0);
        instr(1'b1, 4'h5, 20'h00004);
        chk(got, 1'b0);
        instr(1'b0, 4'h2, 20'h00004);
        chk(got, 1'b0);
        instr(1'b1, 4'h5, 20'h00004);
        chk(got, 1'b0);
        instr(1'b0, 4'h8, 20'h00004);
        chk(got, 1'b1);
        chk(vec_src, 5'h02);
        instr(1'b1, 4'h1, 20'h00000);
        // Mid-run reset must drop the priority and primary enable bits written above
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'hB8, 8'hC0);
        rd(8'hA8, 8'h00);
        chk({in_service_hi, in_service_lo}, 2'b00);
        for (t = 0; t < 40; t++)
        begin
            r_en = 8'($random(seed));
            r_pri = 8'($random(seed));
            r_e1 = 8'($random(seed));
            r_e2 = 8'($random(seed));
            @(posedge clk);
            ext_high_prio <= 14'($random(seed));
            cfg;
            rd(8'hA8, r_en);
            rd(8'hB8, r_pri | 8'hC0);
            rd(8'hE6, r_e1);
            rd(8'hE7, r_e2 & 8'h5F);
            trial(20'($random(seed)));
        end
        tally_and_finish;
    end
endmodule // tlic_bench
